// file: hw/vpm_mac_slice.sv
// Purpose: Variable precision multiply-accumulate slice with AHB-Lite setup.
// Assumes: Clock and enable strobes come from logic on hclk; clears are async.
// Notes:   All outputs are flops; the output bypass loads the bank every cycle.
`timescale 1ns/100ps
module vpm_mac_slice (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [2:0]  clock_tick,
  input  wire logic [2:0]  clock_enable_select,
  input  wire logic [1:0]  async_clear_line,
  input  wire logic [26:0] upper_leg_operand_first,
  input  wire logic [18:0] upper_leg_operand_second,
  input  wire logic [26:0] preadd_operand_first,
  input  wire logic [18:0] preadd_operand_second,
  input  wire logic [26:0] multiplicand_first,
  input  wire logic [17:0] multiplicand_second,
  input  wire logic [26:0] cascade_in,
  input  wire logic [2:0]  coefficient_pick_a,
  input  wire logic [2:0]  coefficient_pick_b,
  input  wire logic        negate,
  input  wire logic        preload_constant_ctl,
  input  wire logic        accumulate,
  input  wire logic [63:0] preload_value,
  input  wire logic [63:0] chain_in,
  output logic [18:0]      cascade_out,
  output logic [63:0]      chain_out,
  output logic [73:0]      result_out
);
  // Picks one strobe of three; selection 3 never fires
  function automatic logic pick3(input logic [2:0] v, input logic [1:0] s);
    pick3 = (s == 2'd3) ? 1'b0 : v[s];
  endfunction

  // Extends the low w bits of a, signed or unsigned, to 27 bits
  function automatic logic [26:0] ext27(input logic [26:0] a, input int w, input logic sgn);
    logic [26:0] r;
    r = '0;
    for (int i = 0; i < 27; i++) begin
      r[i] = (i < w) ? a[i] : (sgn & a[w-1]);
    end
    ext27 = r;
  endfunction

  // Pre-adder: sum or difference of two w-bit operands
  function automatic logic [26:0] preadd(input logic [26:0] a, input logic [26:0] b,
                                         input logic sub, input logic sgn, input int w);
    logic [26:0] ea;
    logic [26:0] eb;
    ea = ext27(a, w, sgn);
    eb = ext27(b, w, sgn);
    preadd = sub ? ea - eb : ea + eb;
  endfunction

  // Product lanes for every mode; unused lanes read as zero
  function automatic logic [73:0] product(input vpm_pkg::vpm_mode_t m, input logic [26:0] y0,
                                          input logic [18:0] y1, input logic [26:0] x0,
                                          input logic [17:0] x1, input logic xs);
    logic signed [53:0] p54;
    logic signed [36:0] pa;
    logic signed [36:0] pb;
    logic [73:0]        r;
    p54 = '0;
    pa  = '0;
    pb  = '0;
    r   = '0;
    unique case (m)
      vpm_pkg::VPM_M27X27: begin
        p54 = $signed(y0) * $signed(x0);
        r[63:0] = {{10{p54[53]}}, p54};
      end
      vpm_pkg::VPM_DUAL_18X19: begin
        pa = 37'($signed(y0[18:0]) * $signed({xs & x0[17], x0[17:0]}));
        pb = 37'($signed(y1) * $signed({xs & x1[17], x1}));
        r  = {pb, pa};
      end
      vpm_pkg::VPM_TRIPLE_9X9: begin
        for (int k = 0; k < 3; k++) begin
          r[k*18 +: 18] = 18'($signed(y0[k*9 +: 9]) * $signed(x0[k*9 +: 9]));
        end
      end
      vpm_pkg::VPM_DUAL_16X16: begin
        r[31:0]  = 32'($signed(y0[15:0]) * $signed(x0[15:0]));
        r[63:32] = 32'($signed(y1[15:0]) * $signed(x1[15:0]));
      end
      vpm_pkg::VPM_DUAL_18_PART: begin
        r[31:0]  = 32'($signed(y0[17:0]) * $signed(x0[17:0]));
        r[63:32] = 32'($signed(y1[17:0]) * $signed(x1));
      end
      vpm_pkg::VPM_18X18_FULL: begin
        pa = 37'($signed(y0[17:0]) * $signed(x0[17:0]));
        r[63:0] = {{27{pa[36]}}, pa};
      end
      vpm_pkg::VPM_36X18: begin
        p54 = $signed({y1[17:0], y0[17:0]}) * $signed(x0[17:0]);
        r[63:0] = {{10{p54[53]}}, p54};
      end
      default: r = '0;
    endcase
    product = r;
  endfunction

  // Configuration state written by software
  logic [vpm_pkg::CTL_WIDTH-1:0] ctrl;               // Feature switches
  logic [7:0]                    clksel;             // Clock and enable picks
  logic [26:0]                   coef [vpm_pkg::COEF_N];  // Coefficient store
  // Bus pipeline
  logic                          wr_pend;            // Write data phase due
  logic [7:0]                    wr_addr;            // Latched write offset
  // Decoded controls
  vpm_pkg::vpm_mode_t            mode;
  logic                          second_var;
  logic                          dual_mode;          // 18-bit top-leg lanes
  logic                          acc_ok;             // Accumulator usable
  logic                          casc_ok;            // Cascade path usable
  logic                          in_ce;              // Input bank update
  logic                          out_ce;             // Output bank update
  logic                          in_clr_n;           // Input bank clear
  logic                          out_clr_n;          // Output bank clear
  // Input register bank
  logic [26:0]                   y0_r;
  logic [18:0]                   y1_r;
  logic [26:0]                   z0_r;
  logic [18:0]                   z1_r;
  logic [26:0]                   x0_r;
  logic [17:0]                   x1_r;
  logic [26:0]                   y0_dly;             // Delay set for top leg
  logic [18:0]                   y1_dly;
  logic [2:0]                    pick_a_r;
  logic [2:0]                    pick_b_r;
  logic                          neg_r;
  logic                          ld_r;
  logic                          acc_r;
  // Systolic and accumulator state
  logic [18:0]                   sys_y1;             // Upper multiplier inputs
  logic [17:0]                   sys_x1;
  logic [73:0]                   res_r;              // Output register bank
  logic [63:0]                   dacc_r;             // Double accumulation
  // Combinational datapath
  logic [26:0]                   y0_src;
  logic [18:0]                   y1_src;
  logic [26:0]                   y0_op;
  logic [18:0]                   y1_op;
  logic [26:0]                   x0_op;
  logic [17:0]                   x1_op;
  logic                          neg_op;
  logic                          ld_op;
  logic                          acc_op;
  logic [73:0]                   prod;
  logic [63:0]                   fb;
  logic [73:0]                   next_res;

  // Control decode
  assign mode       = vpm_pkg::vpm_mode_t'(ctrl[vpm_pkg::CTL_MODE +: 3]);
  assign second_var = ctrl[vpm_pkg::CTL_VARIANT];
  assign dual_mode  = mode inside {vpm_pkg::VPM_DUAL_18X19, vpm_pkg::VPM_DUAL_16X16,
                                   vpm_pkg::VPM_DUAL_18_PART};
  // Dual 18x19 and triple 9x9 lanes have no room for feedback; multi-slice work has none
  assign acc_ok     = !(mode inside {vpm_pkg::VPM_DUAL_18X19, vpm_pkg::VPM_TRIPLE_9X9}) &&
                      !ctrl[vpm_pkg::CTL_MULTI];
  assign casc_ok    = ctrl[vpm_pkg::CTL_CASC_EN] && !ctrl[vpm_pkg::CTL_PRE_EN];
  // One strobe pick serves every input register, so pre-added data stay aligned
  assign in_ce      = pick3(clock_tick, clksel[vpm_pkg::SEL_IN_CLK +: 2]) &
                      pick3(clock_enable_select, clksel[vpm_pkg::SEL_IN_ENA +: 2]);
  assign out_ce     = pick3(clock_tick, clksel[vpm_pkg::SEL_OUT_CLK +: 2]) &
                      pick3(clock_enable_select, clksel[vpm_pkg::SEL_OUT_ENA +: 2]);
  // Clears act at once, without the clock
  assign in_clr_n   = hresetn & ~async_clear_line[0];
  assign out_clr_n  = hresetn & ~async_clear_line[1];

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend <= hsel && htrans[1] && hwrite;
        wr_addr <= haddr[7:0];
        // Read data is captured at the address phase
        if (hsel && htrans[1] && !hwrite) begin
          if (haddr[7:0] == vpm_pkg::OFF_CTRL) begin
            hrdata <= {15'h0000, ctrl};
          end else if (haddr[7:0] == vpm_pkg::OFF_CLKSEL) begin
            hrdata <= {24'h000000, clksel};
          end else if (haddr[7:0] == vpm_pkg::OFF_STATUS) begin
            hrdata <= {29'h00000000, casc_ok, acc_ok, dual_mode};
          end else if (haddr[7:0] == vpm_pkg::OFF_RES_LO) begin
            hrdata <= res_r[31:0];
          end else if (haddr[7:0] == vpm_pkg::OFF_RES_HI) begin
            hrdata <= res_r[63:32];
          end else if (haddr[7:0] == vpm_pkg::OFF_RES_EXT) begin
            hrdata <= {22'h000000, res_r[73:64]};
          end else if (haddr[7:5] == vpm_pkg::OFF_COEF[7:5] && haddr[1:0] == 2'h0) begin
            hrdata <= {5'h00, coef[haddr[4:2]]};
          end else begin
            hrdata <= 32'h00000000;  // Unmapped reads as zero
          end
        end
      end
    end
  end

  // Configuration writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl   <= vpm_pkg::CTRL_RESET;
      clksel <= vpm_pkg::CLKSEL_RESET;
      for (int i = 0; i < vpm_pkg::COEF_N; i++) begin
        coef[i] <= 27'h0000000;
      end
    end else if (wr_pend) begin
      if (wr_addr == vpm_pkg::OFF_CTRL) begin
        ctrl <= hwdata[vpm_pkg::CTL_WIDTH-1:0];
      end else if (wr_addr == vpm_pkg::OFF_CLKSEL) begin
        clksel <= hwdata[7:0];
      end else if (wr_addr[7:5] == vpm_pkg::OFF_COEF[7:5] && wr_addr[1:0] == 2'h0) begin
        coef[wr_addr[4:2]] <= hwdata[26:0];
      end
    end
  end

  // Top-leg sources: routing or the cascade chain, the second lane fed by the tap line
  always_comb begin
    y0_src = casc_ok ? cascade_in : upper_leg_operand_first;
    y1_src = (casc_ok && dual_mode) ? y0_r[18:0] : upper_leg_operand_second;
  end

  // Input register bank with delay set
  always_ff @(posedge hclk or negedge in_clr_n) begin
    if (!in_clr_n) begin
      y0_r     <= '0;
      y1_r     <= '0;
      z0_r     <= '0;
      z1_r     <= '0;
      x0_r     <= '0;
      x1_r     <= '0;
      y0_dly   <= '0;
      y1_dly   <= '0;
      pick_a_r <= '0;
      pick_b_r <= '0;
      neg_r    <= 1'b0;
      ld_r     <= 1'b0;
      acc_r    <= 1'b0;
    end else if (in_ce) begin
      y0_r     <= y0_src;
      y1_r     <= y1_src;
      z0_r     <= preadd_operand_first;
      z1_r     <= preadd_operand_second;
      x0_r     <= multiplicand_first;
      x1_r     <= multiplicand_second;
      y0_dly   <= y0_r;
      y1_dly   <= y1_r;
      pick_a_r <= coefficient_pick_a;
      pick_b_r <= coefficient_pick_b;
      neg_r    <= negate;
      ld_r     <= preload_constant_ctl;
      acc_r    <= accumulate;
    end
  end

  // Operand selection: bypass, delay, pre-adder and coefficients
  always_comb begin
    logic [26:0] y0_b;
    logic [18:0] y1_b;
    logic [26:0] z0_b;
    logic [18:0] z1_b;
    logic        byp;
    logic        use_dly;
    int          w27;
    int          w18;
    w18     = 17;  // Narrow lane width until the variant picks
    byp     = ctrl[vpm_pkg::CTL_IN_BYP];
    use_dly = ctrl[vpm_pkg::CTL_DELAY_EN] && (dual_mode || mode == vpm_pkg::VPM_18X18_FULL);
    // Bypass feeds the multiplier straight from the ports
    y0_b   = byp ? y0_src : (use_dly ? y0_dly : y0_r);
    y1_b   = byp ? y1_src : (use_dly ? y1_dly : y1_r);
    z0_b   = byp ? preadd_operand_first : z0_r;
    z1_b   = byp ? preadd_operand_second : z1_r;
    x0_op  = byp ? multiplicand_first : x0_r;
    x1_op  = byp ? multiplicand_second : x1_r;
    neg_op = byp ? negate : neg_r;
    ld_op  = byp ? preload_constant_ctl : ld_r;
    acc_op = byp ? accumulate : acc_r;
    // Operand widths differ between the two variants
    w27 = second_var ? 25 : 26;
    if (second_var) begin
      w18 = 17;
    end else begin
      w18 = ctrl[vpm_pkg::CTL_PRE_SGN] ? 18 : 17;
    end
    y0_op = y0_b;
    y1_op = y1_b;
    if (ctrl[vpm_pkg::CTL_PRE_EN]) begin
      if (dual_mode) begin
        // Two independent narrow pre-adders
        y0_op = {8'h00, 19'(preadd(y0_b, z0_b, ctrl[vpm_pkg::CTL_PRE_SUB],
                                   ctrl[vpm_pkg::CTL_PRE_SGN], w18))};
        y1_op = 19'(preadd({8'h00, y1_b}, {8'h00, z1_b}, ctrl[vpm_pkg::CTL_PRE_SUB],
                           ctrl[vpm_pkg::CTL_PRE_SGN], w18));
      end else begin
        // Both joined as one wide pre-adder
        y0_op = preadd(y0_b, z0_b, ctrl[vpm_pkg::CTL_PRE_SUB], 1'b1, w27);
      end
    end
    if (ctrl[vpm_pkg::CTL_COEF_EN]) begin
      x0_op = coef[byp ? coefficient_pick_a : pick_a_r];
      x1_op = coef[byp ? coefficient_pick_b : pick_b_r][17:0];
    end
  end

  // Upper multiplier systolic set, on the output bank's strobe
  always_ff @(posedge hclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      sys_y1 <= '0;
      sys_x1 <= '0;
    end else if (out_ce) begin
      sys_y1 <= y1_op;
      sys_x1 <= x1_op;
    end
  end

  // Multipliers; the systolic set is skipped outside systolic mode
  always_comb begin
    prod = product(mode, y0_op, ctrl[vpm_pkg::CTL_SYS_EN] ? sys_y1 : y1_op, x0_op,
                   ctrl[vpm_pkg::CTL_SYS_EN] ? sys_x1 : x1_op,
                   ctrl[vpm_pkg::CTL_X_SGN]);
  end

  // Feedback: one extra cycle when double accumulation is on (first variant only)
  assign fb = (ctrl[vpm_pkg::CTL_DACC_EN] && !second_var) ? dacc_r : res_r[63:0];

  // Adder and accumulator
  always_comb begin
    logic [63:0] p64;
    logic [63:0] base;
    base     = 64'h0000000000000000;  // Lane modes leave the wide sum unused
    p64      = prod[63:0];
    next_res = prod;  // Lane modes: each lane's own adder passes its product
    if (acc_ok) begin
      if (acc_op) begin
        base = neg_op ? fb - p64 : fb + p64;
      end else if (ld_op && !neg_op) begin
        base = preload_value + p64;  // Rounding constant from the fabric
      end else begin
        base = p64;  // Zeroing drops the old sum
      end
      if (ctrl[vpm_pkg::CTL_CHAIN_EN]) begin
        base = base + chain_in;
      end
      next_res = {10'h000, base};  // One 64-bit adder
    end
  end

  // Output register bank; bypass loads it every cycle
  always_ff @(posedge hclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      res_r <= '0;
    end else if (out_ce || ctrl[vpm_pkg::CTL_OUT_BYP]) begin
      res_r <= next_res;
    end
  end

  // Double accumulation register shares the bank's strobe and clear
  always_ff @(posedge hclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      dacc_r <= '0;
    end else if (out_ce) begin
      dacc_r <= res_r[63:0];
    end
  end

  // Chainout: systolic mode sends the previous result, one bank cycle later
  always_ff @(posedge hclk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      chain_out <= '0;
    end else if (out_ce || ctrl[vpm_pkg::CTL_OUT_BYP]) begin
      chain_out <= ctrl[vpm_pkg::CTL_SYS_EN] ? res_r[63:0] : next_res[63:0];
    end
  end

  // Cascade toward the next slice taps the delayed second lane
  assign cascade_out = y1_dly;
  assign result_out  = res_r;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_acc_step;
    out_ce && acc_ok && acc_op && !ctrl[vpm_pkg::CTL_CHAIN_EN];
  endsequence

  chk_in_clear_zero: assert property (async_clear_line[0] |-> y0_r == '0 && x0_r == '0)
    else $error("input bank not cleared");
  chk_out_clear_zero: assert property (async_clear_line[1] |-> result_out == '0)
    else $error("output bank not cleared");
  // A clear raised before the next edge legally zeroes the bank, so it ends these checks
  chk_accum_add: assert property (s_acc_step ##0 !neg_op && !async_clear_line[1]
    ##1 !async_clear_line[1] |-> res_r[63:0] == $past(fb) + $past(prod[63:0]))
    else $error("accumulate sum wrong");
  chk_decimate_sub: assert property (s_acc_step ##0 neg_op && !async_clear_line[1]
    ##1 !async_clear_line[1] |-> res_r[63:0] == $past(fb) - $past(prod[63:0]))
    else $error("decimation sum wrong");
  chk_lane_no_acc: assert property (out_ce && mode == vpm_pkg::VPM_DUAL_18X19 && !async_clear_line[1]
    ##1 !async_clear_line[1] |-> res_r == $past(prod))
    else $error("dual lanes accumulated");
  chk_cascade_blocked: assert property (ctrl[vpm_pkg::CTL_PRE_EN] |-> !casc_ok)
    else $error("cascade with pre-adder");
  chk_chain_systolic: assert property (out_ce && ctrl[vpm_pkg::CTL_SYS_EN] && !async_clear_line[1]
    ##1 !async_clear_line[1] |-> chain_out == $past(res_r[63:0]))
    else $error("chainout not delayed");
  chk_dacc_feedback: assert property (ctrl[vpm_pkg::CTL_DACC_EN] && !second_var
    |-> fb == dacc_r)
    else $error("feedback not via double register");
  chk_hold_no_ce: assert property (!out_ce && !ctrl[vpm_pkg::CTL_OUT_BYP] && !async_clear_line[1]
    && !wr_pend ##1 !async_clear_line[1] |-> $stable(res_r))
    else $error("output bank moved without enable");
endmodule

// file: hw/vpm_pkg.sv
// Functional notes
// - Chainout path adds results from other slices
// - Registers rise-edge triggered, zero after power-up
// - Each operand registered or bypassed to multiplier
// - Input registers: clock, enable, clear zero
// - Delay registers balance cascade plus chainout latency
// - Top-leg operands from routing or cascade chain
// - First variant: two 19-bit or one 27-bit pre-adder
// - First variant pre-adder widths, add or subtract
// - Second variant: 18-bit or 26-bit pre-adders
// - Multiplicand from input or eight stored coefficients
// - First variant: 27x27, dual 18x19, triple 9x9
// - Second variant adds 16x16, partial, 18x18, 36x18
// - Adder: 64-bit, dual 37-bit or triple 18-bit
// - No accumulation or chaining in dual 18x19/triple 9x9 modes
// - Negate, preload, accumulate controls decode the accumulator
// - Two systolic sets, bypassed outside systolic mode
// - Systolic registers use output bank clock
// - First variant: double accumulation delays feedback one cycle
// - Double accumulation uses output bank selections
// - Bypassable 64-bit output bank, clear one; the code's bypass still registers, loading the bank every cycle
// - Pre-adder forces one common input clock
// - No input cascading while pre-adder enabled
// - No accumulation in multi-slice operation
//
// Purpose: Constants, register map and modes of the multiply-accumulate slice.
// Assumes: AHB-Lite word registers, one system clock with enable strobes.
// Notes:   Selection value 3 in a clock or enable field means "never".
package vpm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;  // Mode and feature switches
  localparam logic [7:0] OFF_CLKSEL  = 8'h04;  // Clock and enable selections
  localparam logic [7:0] OFF_STATUS  = 8'h08;  // Read-only state
  localparam logic [7:0] OFF_RES_LO  = 8'h0C;  // Result bits 31..0
  localparam logic [7:0] OFF_RES_HI  = 8'h10;  // Result bits 63..32
  localparam logic [7:0] OFF_RES_EXT = 8'h14;  // Result bits 73..64
  localparam logic [7:0] OFF_COEF    = 8'h20;  // Eight coefficient words follow
  // CTRL field positions
  localparam int CTL_MODE     = 0;   // 3-bit mode code
  localparam int CTL_VARIANT  = 3;   // 0 first variant, 1 second
  localparam int CTL_IN_BYP   = 4;
  localparam int CTL_OUT_BYP  = 5;
  localparam int CTL_PRE_EN   = 6;
  localparam int CTL_PRE_SUB  = 7;
  localparam int CTL_PRE_SGN  = 8;
  localparam int CTL_COEF_EN  = 9;
  localparam int CTL_CASC_EN  = 10;
  localparam int CTL_DELAY_EN = 11;
  localparam int CTL_SYS_EN   = 12;
  localparam int CTL_DACC_EN  = 13;
  localparam int CTL_CHAIN_EN = 14;
  localparam int CTL_MULTI    = 15;
  localparam int CTL_X_SGN    = 16;
  localparam int CTL_WIDTH    = 17;
  // CLKSEL field positions, two bits each
  localparam int SEL_IN_CLK   = 0;
  localparam int SEL_IN_ENA   = 2;
  localparam int SEL_OUT_CLK  = 4;
  localparam int SEL_OUT_ENA  = 6;
  // Reset values
  localparam logic [CTL_WIDTH-1:0] CTRL_RESET   = 17'h00000;
  localparam logic [7:0]           CLKSEL_RESET = 8'h00;
  // Widths
  localparam int RES_W  = 74;  // 64-bit bank plus dual-lane extension
  localparam int COEF_N = 8;
  // Operating modes
  typedef enum logic [2:0] {
    VPM_M27X27, VPM_DUAL_18X19, VPM_TRIPLE_9X9, VPM_DUAL_16X16,
    VPM_DUAL_18_PART, VPM_18X18_FULL, VPM_36X18
  } vpm_mode_t;
endpackage

// file: tb/vpm_fabric_model.sv
// Purpose: Upstream slice and fabric logic feeding the chain and preload inputs.
// Assumes: The upstream chain output is a register on hclk, cleared in reset.
// Notes:   The rounding constant is built from a bit index, so it has one bit set.
`timescale 1ns/100ps
module vpm_fabric_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [5:0]  round_bit,
  input  wire logic [63:0] chain_value,
  output logic      [63:0] preload_value,
  output logic      [63:0] chain_in
);
  // A shifted single one can never carry two set bits
  assign preload_value = 64'h1 << round_bit;
  // Previous slice output register, so the chain lags its source by one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_in <= 64'h0;
    end else begin
      chain_in <= chain_value;
    end
  end
endmodule

// file: tb/variable_precision_mac_slice_tb.sv
// Purpose: Self-checking bench for the multiply-accumulate slice.
// Assumes: Input bank bypassed, output bank too except in t_sys; products 3 x 5 in 27x27 and dual lanes.
// Notes:   Each mac step holds its controls two edges and checks after the first.
`timescale 1ns/100ps
module variable_precision_mac_slice_tb;
  logic        hclk, hresetn, hsel = 0, hwrite = 0, hresp, hreadyout;
  logic        negate = 0, preload_constant_ctl = 0, accumulate = 0;
  logic [1:0]  htrans = 2'h0, async_clear_line = 2'h0;
  logic [2:0]  hsize = 3'h2, clock_tick = 3'h7, clock_enable_select = 3'h7, coef_a = 3'h0, coef_b = 3'h1;
  logic [5:0]  round_bit = 6'h4;
  logic [17:0] mult_b = 18'h0;
  logic [18:0] upper_b = 19'h0, pre_b = 19'h0, cascade_out;
  logic [26:0] upper_a = 27'h3, pre_a = 27'h0, mult_a = 27'h5, cascade_in = 27'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [63:0] preload_value, chain_in, chain_value = 64'h64, chain_out;
  logic [73:0] result_out;
  int          fail_count, num_checks;
  // Single slave, so its ready is the bus ready
  vpm_mac_slice DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .clock_tick(clock_tick), .clock_enable_select(clock_enable_select),
    .async_clear_line(async_clear_line), .upper_leg_operand_first(upper_a), .upper_leg_operand_second(upper_b),
    .preadd_operand_first(pre_a), .preadd_operand_second(pre_b), .multiplicand_first(mult_a),
    .multiplicand_second(mult_b), .cascade_in(cascade_in), .coefficient_pick_a(coef_a),
    .coefficient_pick_b(coef_b), .negate(negate), .preload_constant_ctl(preload_constant_ctl),
    .accumulate(accumulate), .preload_value(preload_value), .chain_in(chain_in),
    .cascade_out(cascade_out), .chain_out(chain_out), .result_out(result_out));
  vpm_fabric_model fabric (.hclk(hclk), .hresetn(hresetn), .round_bit(round_bit),
    .chain_value(chain_value), .preload_value(preload_value), .chain_in(chain_in));
  // Free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Compare and count; four-state equality so an unknown never matches a known value
  task chk(input string n, input logic [73:0] s, input logic [73:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single AHB transfer; read data taken at the data-phase edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Controls {negate, preload, accumulate}; result judged after one edge
  task mac(input logic [2:0] c, input logic [73:0] e, input string n);
    @(posedge hclk);
    {negate, preload_constant_ctl, accumulate} <= c;
    @(posedge hclk);
    @(negedge hclk);
    chk(n, result_out, e);
  endtask
  task t_reset;
    chk("result", result_out, 74'h0);
    chk("chain", {10'h0, chain_out}, 74'h0);
    chk("hresp", {73'h0, hresp}, 74'h0);
    ahb(1'b0, vpm_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", {42'h0, rd}, 74'h0);
    ahb(1'b1, vpm_pkg::OFF_CTRL, 32'h30);
    ahb(1'b0, vpm_pkg::OFF_CTRL, 32'h0);
    chk("ctrl rb", {42'h0, rd}, 74'h30);
    ahb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {42'h0, rd}, 74'h0);
    $display("reset and bus test done");
  endtask
  // Each step also carries one more edge of the previous controls
  task t_acc;
    mac(3'h0, 74'hF, "product");
    mac(3'h1, 74'h1E, "accumulate");
    mac(3'h1, 74'h3C, "accumulate2");
    mac(3'h5, 74'h3C, "decimate");
    mac(3'h2, 74'h1F, "preload");
    mac(3'h3, 74'h2E, "acc ignores load");
    $display("accumulator test done");
  endtask
  task t_chain;
    ahb(1'b1, vpm_pkg::OFF_CTRL, 32'h4030);
    mac(3'h0, 74'h73, "chain sum");
    $display("chain test done");
  endtask
  // Dual 18x19 refuses accumulation, so the lane stays one product
  task t_dual;
    ahb(1'b1, vpm_pkg::OFF_CTRL, 32'h31);
    mac(3'h1, 74'hF, "dual no acc");
    mac(3'h1, 74'hF, "dual no acc2");
    $display("dual mode test done");
  endtask
  // Systolic chain with double accumulation, then a bank held by a low enable
  task t_sys;
    ahb(1'b1, vpm_pkg::OFF_CTRL, 32'h3010);
    mac(3'h1, 74'h1E, "double acc");
    mac(3'h0, 74'hF, "systolic");
    chk("systolic chain", {10'h0, chain_out}, 74'h2D);
    @(posedge hclk);
    clock_enable_select <= 3'h0;
    accumulate <= 1'b1;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("held bank", result_out, 74'hF);
    @(posedge hclk);
    clock_enable_select <= 3'h7;
    accumulate <= 1'b0;
    $display("systolic test done");
  endtask
  // Stored coefficient replaces the dynamic multiplicand: 3 x 7
  task t_coef;
    ahb(1'b1, vpm_pkg::OFF_COEF, 32'h7);
    ahb(1'b1, vpm_pkg::OFF_CTRL, 32'h230);
    mac(3'h0, 74'h15, "coefficient");
    $display("coefficient test done");
  endtask
  // Second top-leg lane reaches the cascade two input strobes later, then both clears
  task t_clear;
    @(posedge hclk);
    upper_b <= 19'h5;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("cascade", {55'h0, cascade_out}, 74'h5);
    @(posedge hclk);
    async_clear_line <= 2'h3;
    #1 chk("clear result", result_out, 74'h0);
    chk("clear chain", {10'h0, chain_out}, 74'h0);
    chk("clear cascade", {55'h0, cascade_out}, 74'h0);
    @(posedge hclk);
    async_clear_line <= 2'h0;
    $display("clear test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Tests need about 70 cycles; 3000 is a hang
  initial begin
    #30000;
    fail_count++;
    final_report;
  end
  initial begin
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    t_reset;
    t_acc;
    t_chain;
    t_dual;
    t_sys;
    t_coef;
    t_clear;
    final_report;
  end
endmodule
